/* File: sector_flash_program_interface_tb_top.sv */
// self-checking bench for the sector flash host controller and flash model
`timescale 1ns/1ps
module sector_flash_program_interface_tb_top;
   // ************************************************************
   // wiring, clock and checking tasks
   // ************************************************************
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   sfpi_pkg::sfpi_op_t cmd_op = sfpi_pkg::OP_READ;
   logic [16:0] cmd_addr = 17'h00000;
   logic guard_on = 1'b0;
   logic byte_valid = 1'b0;
   logic [7:0] byte_data = 8'h00;
   logic [31:0] prog_cyc = 32'h0000001e;
   logic busy, done, tmo, byte_ready, ce_n, oe_n, we_n, dq_oe, f_drv, viol;
   logic [7:0] rd_data, dq_h, dq_f, bus;
   logic [16:0] addr;
   int n_mismatch = 0;
   int comparisons = 0;
   assign bus = dq_oe ? dq_h : dq_f;
   always #50 ref_clk = ~ref_clk;
   sfpi_host #(.POWER_ON_CYCLES(20), .PROGRAM_CYCLES(50)) dut_u (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
      .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .guard_on_i(guard_on),
      .busy_o(busy), .done_o(done), .timeout_o(tmo), .rd_data_o(rd_data), .byte_valid_i(byte_valid),
      .byte_data_i(byte_data), .byte_ready_o(byte_ready), .addr_lines_o(addr), .ce_n_o(ce_n),
      .oe_n_o(oe_n), .we_n_o(we_n), .dq_o(dq_h), .dq_oe_o(dq_oe), .dq_i(bus));
   sfpi_flash_model #(.POR_CYC(20)) flash_u (.clk_i(ref_clk), .prog_cyc_i(prog_cyc), .addr_i(addr),
      .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(bus), .dq_o(dq_f), .drv_o(f_drv), .viol_o(viol));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0d ns: %s got %h", $time, m, got);
      end
   endtask
   task automatic hang(string m);
      n_mismatch++;
      $display("wrong value at %0d ns: %s", $time, m);
      conclude();
   endtask
   // issue one command, feed a whole sector for writes, wait for done
   task automatic cmd(sfpi_pkg::sfpi_op_t op, logic [16:0] a, logic [7:0] seed);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      chk({7'h00, busy}, 8'h01, "busy after take");
      for (int k = 0; k < 128 && op == sfpi_pkg::OP_WRITE; k++) begin
         byte_valid = 1'b1;
         byte_data = 8'(k) ^ seed;
         for (int i = 0; i < 40 && byte_ready !== 1'b1; i++) @(negedge ref_clk);
         if (byte_ready !== 1'b1) hang("no byte ready");
         @(negedge ref_clk);
      end
      byte_valid = 1'b0;
      for (int i = 0; i < 8000 && done !== 1'b1; i++) @(negedge ref_clk);
      if (done !== 1'b1) hang("no done");
   endtask
   task automatic rdc(logic [16:0] a, logic [7:0] exp);
      cmd(sfpi_pkg::OP_READ, a, 8'h00);
      chk(rd_data, exp, "read data");
   endtask
   // bus contention between host and flash drivers
   always @(negedge ref_clk) begin
      if (dq_oe === 1'b1 && f_drv === 1'b1) hang("both drive data");
   end
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      chk({3'h0, busy, ce_n, oe_n, we_n, dq_oe}, 8'h1e, "pins in reset");
      rst_n = 1'b1;
      for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge ref_clk);
      chk({7'h00, busy}, 8'h00, "still busy after power-on");
      $display("test reset done");
   endtask
   task automatic t_write();
      flash_u.mem[17'h1abcd] = 8'h96;
      rdc(17'h1abcd, 8'h96);
      cmd(sfpi_pkg::OP_WRITE, 17'h00180, 8'h25);
      chk({7'h00, tmo}, 8'h00, "write timed out");
      rdc(17'h00180, 8'h25);
      rdc(17'h001bf, 8'h1a);
      rdc(17'h001ff, 8'h5a);
      chk({7'h00, viol}, 8'h00, "flash saw bad load");
      flash_u.id_mode = 1'b1;
      rdc(17'h00000, 8'h5c);
      rdc(17'h00001, 8'hc5);
      flash_u.id_mode = 1'b0;
      $display("test write done");
   endtask
   task automatic t_guard();
      cmd(sfpi_pkg::OP_GUARD_ON, 17'h00000, 8'h00);
      chk({7'h00, flash_u.guard}, 8'h01, "guard not set");
      cmd(sfpi_pkg::OP_WRITE, 17'h00180, 8'h3c);
      rdc(17'h00185, 8'h20);
      guard_on = 1'b1;
      cmd(sfpi_pkg::OP_WRITE, 17'h00180, 8'h3c);
      rdc(17'h00185, 8'h39);
      guard_on = 1'b0;
      cmd(sfpi_pkg::OP_GUARD_OFF, 17'h00000, 8'h00);
      chk({7'h00, flash_u.guard}, 8'h00, "guard not cleared");
      cmd(sfpi_pkg::OP_WRITE, 17'h00180, 8'h42);
      rdc(17'h00185, 8'h47);
      $display("test guard done");
   endtask
   task automatic t_slow();
      logic b6;
      prog_cyc = 32'h00000bb8;
      cmd(sfpi_pkg::OP_WRITE, 17'h00280, 8'ha5);
      chk({7'h00, tmo}, 8'h01, "slow program not timed out");
      cmd(sfpi_pkg::OP_READ, 17'h00280, 8'h00);
      chk({7'h00, rd_data[7]}, 8'h00, "poll bit not inverted");
      b6 = rd_data[6];
      cmd(sfpi_pkg::OP_READ, 17'h00280, 8'h00);
      chk({7'h00, rd_data[6]}, {7'h00, ~b6}, "activity bit did not flip");
      for (int i = 0; i < 4000 && flash_u.busy !== 1'b0; i++) @(negedge ref_clk);
      if (flash_u.busy !== 1'b0) hang("flash never finished");
      prog_cyc = 32'h0000001e;
      rdc(17'h00280, 8'ha5);
      $display("test slow program done");
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      t_reset();
      t_write();
      t_guard();
      t_slow();
      conclude();
   end
endmodule

/* File: sfpi_flash_model.sv */
// behavioural model of the parallel sector flash driven by the host controller
`timescale 1ns/1ps
module sfpi_flash_model #(
   parameter int POR_CYC = 20,
   // enable and disable prefixes share their addresses
   parameter logic [50:0] ON_A = {17'h00001, 17'h00002, 17'h00003},
   parameter logic [23:0] ON_D = {8'h11, 8'h22, 8'h33},
   parameter logic [23:0] OFF_D = {8'h44, 8'h55, 8'h66},
   // identification codes, values arbitrary
   parameter logic [7:0] MAKER_ID = 8'h5c,
   parameter logic [7:0] PART_ID = 8'hc5
) (
   // timer clock and program cycle length in clocks
   input wire logic clk_i,
   input wire logic [31:0] prog_cyc_i,
   // flash pins
   input wire logic [16:0] addr_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o,
   output logic drv_o,
   output logic viol_o
);
   // ************************************************************
   // array, load queue and timers
   // ************************************************************
   logic [7:0] mem [0:131071];
   logic guard = 1'b0;
   logic busy = 1'b0;
   logic in_pulse = 1'b0;
   logic loading = 1'b0;
   logic flip = 1'b0;
   logic id_mode = 1'b0;
   logic [7:0] last = 8'h00;
   logic [7:0] shown = 8'h00;
   logic [16:0] a_lat;
   logic [16:0] la_q[$];
   logic [7:0] ld_q[$];
   int por = 0;
   int pcnt = 0;
   realtime t_fall = 0.0;
   realtime t_rise = 0.0;
   initial begin
      viol_o = 1'b0;
      for (int i = 0; i < 131072; i++) begin
         mem[i] = 8'h00;
      end
   end
   // true when the first three loads carry the given prefix, either order
   function automatic bit pre(logic [23:0] d, bit rev);
      pre = (la_q.size() >= 3);
      for (int i = 0; i < 3; i++) begin
         if (pre && {la_q[i], ld_q[i]} != {ON_A[(rev ? i : 2 - i) * 17 +: 17], d[(rev ? i : 2 - i) * 8 +: 8]})
            pre = 1'b0;
      end
   endfunction
   // end of load period: guard decode, erase and program, start timer
   task automatic close_load();
      int s;
      bit on;
      bit off;
      on = pre(ON_D, 1'b0) || pre(ON_D, 1'b1);
      off = pre(OFF_D, 1'b0) || pre(OFF_D, 1'b1);
      s = (on || off) ? 3 : 0;
      if (la_q.size() > s && (!guard || on)) begin
         for (int j = 0; j < 128; j++) begin
            mem[{la_q[s][16:7], 7'(j)}] = 8'hxx;
         end
         for (int i = s; i < la_q.size(); i++) begin
            if (la_q[i][16:7] != la_q[s][16:7]) viol_o = 1'b1;
            mem[la_q[i]] = ld_q[i];
         end
      end
      if (on) guard = 1'b1;
      else if (off) guard = 1'b0;
      last = ld_q[$];
      busy <= 1'b1;
      pcnt <= 0;
      la_q.delete();
      ld_q.delete();
      loading = 1'b0;
   endtask
   // strobe fall: address taken on the later falling edge
   always @(negedge we_n_i or negedge ce_n_i) begin
      if (!we_n_i && !ce_n_i && oe_n_i) begin
         if (busy) viol_o = 1'b1;
         a_lat = addr_i;
         t_fall = $realtime;
         in_pulse = 1'b1;
      end
   end
   // strobe rise: data taken on the first rising edge, glitches dropped
   always @(posedge we_n_i or posedge ce_n_i) begin
      if (in_pulse) begin
         in_pulse = 1'b0;
         t_rise = $realtime;
         if (t_rise - t_fall >= 15.0 && !busy && por >= POR_CYC) begin
            la_q.push_back(a_lat);
            ld_q.push_back(dq_i);
            loading = 1'b1;
         end
      end
   end
   // power-on delay, program timer and load window
   always @(posedge clk_i) begin
      if (por < POR_CYC) por <= por + 1;
      if (drv_o) shown <= dq_o;
      if (busy) begin
         pcnt <= pcnt + 1;
         if (pcnt + 1 >= prog_cyc_i) busy <= 1'b0;
      end
      if (loading && !in_pulse && $realtime - t_rise >= 150000.0) close_load();
   end
   // activity bit flips on each read while busy
   always @(negedge oe_n_i) begin
      // chip select may fall in the same step; look once it settled
      #1;
      if (busy && !ce_n_i) flip <= ~flip;
   end
   // read path; a released bus shows the inverse of the last value
   assign drv_o = !ce_n_i && !oe_n_i && we_n_i;
   always @* begin
      if (!drv_o) dq_o = ~shown;
      else if (busy) dq_o = {~last[7], flip, last[5:0]};
      else if (id_mode) dq_o = addr_i[0] ? PART_ID : MAKER_ID; // one table for both entry methods
      else dq_o = mem[addr_i];
   end
endmodule

/* File: sfpi_host.sv */
// host-side controller that reads and sector-programs a parallel flash
`timescale 1ns/1ps

// Overview of operation
// (R1) read: chip select and output enable low, write strobe high, then sample data
// (R2) device floats data while chip select or output enable is high
// (R3) each load pulses write strobe low with chip select low, output enable high
// (R4) address set before strobe falls, data held past strobe rise
// (R5) a sector write always loads all bytes of the sector
// (R6) next load falls within window; then wait out window before polling
// (R7) sector bits stay fixed across a load; low bits pick the byte
// (R8) device accepts any byte order; this host loads bytes in ascending order
// (R9) device latches sector and programs it alone after the window closes
// (R10) reads during the program cycle return polling status
// (R11) poll completion bit of last byte; start nothing new until it matches (this host also returns to idle on timeout)
// (R12) guard enable is three loads of fixed address and data
// (R13) with guard on, every sector write opens with the three-load prefix (this host sends it only while guard_on_i is high)
// (R14) prefix loads use the same strobe timing as data loads
// (R15) guard state persists until the disable sequence
// (R16) guard starts disabled on a new device
// (R17) unprefixed write under guard only runs the timer; poll still completes
// (R18) device refuses programming with output enable low or strobe high
// (R19) strobes shorter than the glitch filter are ignored by the device
// (R20) no programming until the power-on delay has run out
// (R21) identification codes match for both entry methods
// (R22) polling returns complement of last byte bit 7 until done
// (R23) activity bit flips on each read while busy
// (R24) host releases data drivers before output enable goes low
module sfpi_host #(
   parameter int POWER_ON_CYCLES = sfpi_pkg::POWER_ON_CYC,
   parameter int PROGRAM_CYCLES = sfpi_pkg::PROGRAM_CYCLE_CYC,
   parameter logic [3*sfpi_pkg::ADDR_W-1:0] GUARD_ON_ADDR = {17'h00001, 17'h00002, 17'h00003},
   parameter logic [3*sfpi_pkg::DATA_W-1:0] GUARD_ON_DATA = {8'h11, 8'h22, 8'h33},
   parameter logic [3*sfpi_pkg::ADDR_W-1:0] GUARD_OFF_ADDR = {17'h00001, 17'h00002, 17'h00003},
   parameter logic [3*sfpi_pkg::DATA_W-1:0] GUARD_OFF_DATA = {8'h44, 8'h55, 8'h66}
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // user command port
   input wire logic cmd_valid_i,
   input wire sfpi_pkg::sfpi_op_t cmd_op_i,
   input wire logic [sfpi_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic guard_on_i,
   output logic busy_o,
   output logic done_o,
   output logic timeout_o,
   output logic [sfpi_pkg::DATA_W-1:0] rd_data_o,
   // sector byte stream
   input wire logic byte_valid_i,
   input wire logic [sfpi_pkg::DATA_W-1:0] byte_data_i,
   output logic byte_ready_o,
   // flash pins
   output logic [sfpi_pkg::ADDR_W-1:0] addr_lines_o,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [sfpi_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [sfpi_pkg::DATA_W-1:0] dq_i
);
   // ************************************************************
   // state and working registers
   // ************************************************************
   sfpi_pkg::sfpi_state_t state;
   sfpi_pkg::sfpi_op_t op;
   logic [sfpi_pkg::SECTOR_W-1:0] sector;
   logic [sfpi_pkg::IDX_W-1:0] ld_idx;
   logic [sfpi_pkg::IDX_W-1:0] pre_len;
   logic [sfpi_pkg::IDX_W-1:0] total_len;
   logic [sfpi_pkg::CNT_W-1:0] cnt;
   logic [sfpi_pkg::CNT_W-1:0] tmo_cnt;
   logic last_bit;
   logic [sfpi_pkg::ADDR_W-1:0] tbl_addr;
   logic [sfpi_pkg::DATA_W-1:0] tbl_data;
   logic [sfpi_pkg::IDX_W-1:0] next_idx;

   // ************************************************************
   // prefix table lookup
   // ************************************************************
   // guard-off uses its own table, everything else the enable prefix
   always_comb begin
      tbl_addr = '0;
      tbl_data = '0;
      if (op == sfpi_pkg::OP_GUARD_OFF) begin
         tbl_addr = GUARD_OFF_ADDR[(2 - ld_idx[1:0]) * sfpi_pkg::ADDR_W +: sfpi_pkg::ADDR_W];
         tbl_data = GUARD_OFF_DATA[(2 - ld_idx[1:0]) * sfpi_pkg::DATA_W +: sfpi_pkg::DATA_W];
      end else begin
         tbl_addr = GUARD_ON_ADDR[(2 - ld_idx[1:0]) * sfpi_pkg::ADDR_W +: sfpi_pkg::ADDR_W];
         tbl_data = GUARD_ON_DATA[(2 - ld_idx[1:0]) * sfpi_pkg::DATA_W +: sfpi_pkg::DATA_W];
      end
   end

   assign next_idx = ld_idx + 8'h01;

   // ************************************************************
   // sequencer
   // ************************************************************
   // one process drives pins and stream handshake
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state <= sfpi_pkg::ST_POR;
         op <= sfpi_pkg::OP_READ;
         sector <= '0;
         ld_idx <= '0;
         pre_len <= '0;
         total_len <= '0;
         cnt <= '0;
         tmo_cnt <= '0;
         last_bit <= 1'b0;
         busy_o <= 1'b1;
         done_o <= 1'b0;
         timeout_o <= 1'b0;
         rd_data_o <= '0;
         byte_ready_o <= 1'b0;
         addr_lines_o <= '0;
         ce_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         we_n_o <= 1'b1;
         dq_o <= '0;
         dq_oe_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (state)
            sfpi_pkg::ST_POR: begin
               // hold off all access until the power-on delay ran out
               cnt <= cnt + 17'h00001;
               if (cnt >= sfpi_pkg::CNT_W'(POWER_ON_CYCLES - 1)) begin // [R20]
                  busy_o <= 1'b0;
                  state <= sfpi_pkg::ST_IDLE;
               end
            end
            sfpi_pkg::ST_IDLE: begin
               if (cmd_valid_i) begin
                  busy_o <= 1'b1;
                  timeout_o <= 1'b0;
                  op <= cmd_op_i;
                  sector <= cmd_addr_i[sfpi_pkg::ADDR_W-1:sfpi_pkg::BYTE_ADDR_W]; // [R7]
                  ld_idx <= '0;
                  if (cmd_op_i == sfpi_pkg::OP_READ) begin
                     // data drivers already off here [R24]
                     addr_lines_o <= cmd_addr_i;
                     ce_n_o <= 1'b0;
                     oe_n_o <= 1'b0; // [R1]
                     state <= sfpi_pkg::ST_RD_ON;
                  end else if (cmd_op_i == sfpi_pkg::OP_WRITE && !guard_on_i) begin
                     pre_len <= '0;
                     total_len <= sfpi_pkg::IDX_W'(sfpi_pkg::SECTOR_BYTES); // [R5]
                     byte_ready_o <= 1'b1;
                     state <= sfpi_pkg::ST_FETCH;
                  end else begin
                     // prefix first for guard commands and for writes with guard_on_i high [R13]
                     pre_len <= sfpi_pkg::IDX_W'(sfpi_pkg::PREFIX_LEN); // [R12]
                     total_len <= (cmd_op_i == sfpi_pkg::OP_WRITE) ?
                        sfpi_pkg::IDX_W'(sfpi_pkg::PREFIX_LEN + sfpi_pkg::SECTOR_BYTES) :
                        sfpi_pkg::IDX_W'(sfpi_pkg::PREFIX_LEN);
                     state <= sfpi_pkg::ST_SETUP;
                     ce_n_o <= 1'b1;
                  end
               end
            end
            sfpi_pkg::ST_FETCH: begin
               // take the next sector byte; address is its load index less the prefix length [R8]
               if (byte_ready_o && byte_valid_i) begin
                  byte_ready_o <= 1'b0;
                  addr_lines_o <= {sector, sfpi_pkg::BYTE_ADDR_W'(ld_idx - pre_len)};
                  dq_o <= byte_data_i;
                  last_bit <= byte_data_i[sfpi_pkg::POLL_BIT];
                  dq_oe_o <= 1'b1;
                  ce_n_o <= 1'b0;
                  state <= sfpi_pkg::ST_STROBE;
               end
            end
            sfpi_pkg::ST_SETUP: begin
               // prefix load: same timing as a data load [R14]
               addr_lines_o <= tbl_addr;
               dq_o <= tbl_data;
               last_bit <= tbl_data[sfpi_pkg::POLL_BIT];
               dq_oe_o <= 1'b1;
               ce_n_o <= 1'b0;
               state <= sfpi_pkg::ST_STROBE;
            end
            sfpi_pkg::ST_STROBE: begin
               // address is settled; strobe falls with oe high [R3] [R4]
               we_n_o <= 1'b0;
               state <= sfpi_pkg::ST_RELEASE;
            end
            sfpi_pkg::ST_RELEASE: begin
               // one full cycle low, far wider than the glitch filter [R19]
               we_n_o <= 1'b1;
               state <= sfpi_pkg::ST_CLOSE;
               cnt <= '0;
               tmo_cnt <= '0;
               ld_idx <= next_idx;
               if (next_idx < total_len) begin
                  // next falling edge a few cycles later, inside the window [R6]
                  if (next_idx < pre_len) begin
                     state <= sfpi_pkg::ST_SETUP;
                  end else begin
                     byte_ready_o <= 1'b1;
                     state <= sfpi_pkg::ST_FETCH;
                  end
               end
            end
            sfpi_pkg::ST_CLOSE: begin
               // deselect, drop data, let the load window expire [R6] [R9]
               ce_n_o <= 1'b1;
               dq_oe_o <= 1'b0;
               cnt <= cnt + 17'h00001;
               tmo_cnt <= tmo_cnt + 17'h00001;
               if (cnt >= sfpi_pkg::CNT_W'(sfpi_pkg::LOAD_WINDOW_CYC - 1)) begin
                  ce_n_o <= 1'b0;
                  oe_n_o <= 1'b0;
                  state <= sfpi_pkg::ST_POLL_ON;
               end
            end
            sfpi_pkg::ST_POLL_ON: begin
               tmo_cnt <= tmo_cnt + 17'h00001;
               state <= sfpi_pkg::ST_POLL_SMP;
            end
            sfpi_pkg::ST_POLL_SMP: begin
               // completion when bit 7 matches the last byte loaded [R11] [R22] [R17]
               tmo_cnt <= tmo_cnt + 17'h00001;
               ce_n_o <= 1'b1;
               oe_n_o <= 1'b1;
               rd_data_o <= dq_i;
               if (dq_i[sfpi_pkg::POLL_BIT] == last_bit) begin
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  state <= sfpi_pkg::ST_IDLE;
               end else if (tmo_cnt >= sfpi_pkg::CNT_W'(PROGRAM_CYCLES + sfpi_pkg::LOAD_WINDOW_CYC)) begin
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  timeout_o <= 1'b1;
                  state <= sfpi_pkg::ST_IDLE;
               end else begin
                  state <= sfpi_pkg::ST_POLL_OFF;
               end
            end
            sfpi_pkg::ST_POLL_OFF: begin
               // a gap between polls gives the device a fresh read [R10]
               tmo_cnt <= tmo_cnt + 17'h00001;
               ce_n_o <= 1'b0;
               oe_n_o <= 1'b0;
               state <= sfpi_pkg::ST_POLL_ON;
            end
            sfpi_pkg::ST_RD_ON: begin
               state <= sfpi_pkg::ST_RD_SMP;
            end
            sfpi_pkg::ST_RD_SMP: begin
               rd_data_o <= dq_i;
               ce_n_o <= 1'b1;
               oe_n_o <= 1'b1;
               busy_o <= 1'b0;
               done_o <= 1'b1;
               state <= sfpi_pkg::ST_IDLE;
            end
            default: begin
               state <= sfpi_pkg::ST_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_load_pulse;
      !we_n_o ##1 we_n_o;
   endsequence

   property p_read_we_high;
      @(posedge ref_clk_i) disable iff (!rst_n_i) !oe_n_o |-> we_n_o && !dq_oe_o;
   endproperty
   a_read_we_high: assert property (p_read_we_high) else $error("oe low with strobe or data drive"); // [R1]

   property p_no_contention;
      @(posedge ref_clk_i) disable iff (!rst_n_i) $fell(oe_n_o) |-> $past(dq_oe_o) == 1'b0;
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("data driven as oe fell"); // [R24]

   property p_load_shape;
      @(posedge ref_clk_i) disable iff (!rst_n_i) $fell(we_n_o) |-> !ce_n_o && oe_n_o && dq_oe_o;
   endproperty
   a_load_shape: assert property (p_load_shape) else $error("bad load conditions"); // [R3]

   property p_pulse_width;
      @(posedge ref_clk_i) disable iff (!rst_n_i) $fell(we_n_o) |-> s_load_pulse;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("strobe not one cycle"); // [R19]

   property p_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i) $fell(we_n_o) |=> $stable(addr_lines_o) && $stable(dq_o) && dq_oe_o;
   endproperty
   a_hold: assert property (p_hold) else $error("address or data moved under strobe"); // [R4]

   property p_sector_fixed;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
         $fell(we_n_o) && op == sfpi_pkg::OP_WRITE && ld_idx >= pre_len |->
         addr_lines_o[sfpi_pkg::ADDR_W-1:sfpi_pkg::BYTE_ADDR_W] == sector;
   endproperty
   a_sector_fixed: assert property (p_sector_fixed) else $error("sector bits changed in load"); // [R7]

   property p_window_wait;
      @(posedge ref_clk_i) disable iff (!rst_n_i) $rose(we_n_o) && state == sfpi_pkg::ST_CLOSE |-> oe_n_o [*8];
   endproperty
   a_window_wait: assert property (p_window_wait) else $error("poll inside load window"); // [R6]

   property p_por_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i) state == sfpi_pkg::ST_POR |-> we_n_o && ce_n_o && busy_o;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("access before power-on delay"); // [R20]

   property p_done_match;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
         done_o && !timeout_o && $past(state) == sfpi_pkg::ST_POLL_SMP |-> rd_data_o[sfpi_pkg::POLL_BIT] == last_bit;
   endproperty
   a_done_match: assert property (p_done_match) else $error("done without poll match"); // [R11]
endmodule

/* File: sfpi_pkg.sv */
// shared constants for the sector flash programming controller
package sfpi_pkg;
   // ************************************************************
   // pin widths and sector geometry
   // ************************************************************
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int BYTE_ADDR_W = 7;
   localparam int SECTOR_W = 10;
   localparam int SECTOR_BYTES = 128;
   localparam int PREFIX_LEN = 3;
   localparam int POLL_BIT = 7;
   localparam int IDX_W = 8;
   localparam int CNT_W = 17;

   // ************************************************************
   // timing, each figure in its own unit
   // ************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int LOAD_WINDOW_US = 150;
   localparam int PROGRAM_CYCLE_TIME_MS = 10;
   localparam int POWER_ON_DELAY_MS = 5;
   // load window is a least wait before polling: round up, one cycle spare
   localparam int LOAD_WINDOW_CYC = (LOAD_WINDOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int PROGRAM_CYCLE_CYC = PROGRAM_CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int POWER_ON_CYC = POWER_ON_DELAY_MS * 1000000 / CLK_PERIOD_NS;

   // ************************************************************
   // commands and states
   // ************************************************************
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_GUARD_ON = 2'h2,
      OP_GUARD_OFF = 2'h3
   } sfpi_op_t;

   typedef enum logic [3:0] {
      ST_POR = 4'h0,
      ST_IDLE = 4'h1,
      ST_FETCH = 4'h3,
      ST_SETUP = 4'h2,
      ST_STROBE = 4'h6,
      ST_RELEASE = 4'h7,
      ST_CLOSE = 4'h5,
      ST_POLL_ON = 4'h4,
      ST_POLL_SMP = 4'hc,
      ST_POLL_OFF = 4'hd,
      ST_RD_ON = 4'hf,
      ST_RD_SMP = 4'he
   } sfpi_state_t;
endpackage
